// [hdl/gpmlc_top.sv]
// pin function, input latching, soft reset, ir and rs-485 direction control
// assumes a decoded register port, uart status strobes and synchronous pins
`default_nettype none
`timescale 1ns/1ns
// How it works
// RQ1: the soft reset bit clears itself after the reset, reading back zero.
// RQ2: low select bit picks gpio or second channel modem on pins 3..0.
// RQ3: high select bit picks gpio or first channel modem on pins 7..4.
// RQ4: without latching, an input that reverts before a read withdraws its flag.
// RQ5: with latching, the flag stays and the state bit holds the causing level.
// RQ6: ir mode zero makes pulses of 3/16 of a bit.
// RQ7: ir mode one makes pulses of 1/4 of a bit.
// RQ8: the polarity bit only matters while auto direction is on.
// RQ9: polarity zero: rts low while sending, high while receiving.
// RQ10: polarity one: rts high while sending, low while receiving.
// RQ11: auto direction on lets the transmitter own rts, off it does not.
// RQ12: writing one to the soft reset bit resets the device.
// RQ13: pins in modem use ignore their interrupt enable bits.
// RQ14: enabled inputs that change flag an interrupt, cleared by state read.
module gpmlc_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire gpmlc_pkg::gpmlc_reg_req_t reg_req,
    output gpmlc_pkg::gpmlc_reg_rsp_t reg_rsp,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_dir,
    input wire logic [7:0] gpio_out_val,
    input wire logic [7:0] pin_interrupt_enable,
    output gpmlc_pkg::gpmlc_pins_t gpio_pins,
    input wire logic terminal_ready_first_n,
    input wire logic terminal_ready_second_n,
    output gpmlc_pkg::gpmlc_modem_t modem_first,
    output gpmlc_pkg::gpmlc_modem_t modem_second,
    input wire logic uart_txing,
    input wire logic rts_req_n,
    output logic rts_n,
    input wire logic tick16,
    input wire logic tx_bit_start,
    input wire logic txd,
    output logic ir_tx,
    output logic [7:0] extra_ctrl,
    output logic soft_rst,
    output logic pin_irq
);
    import gpmlc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] extra_line_features_control;
        logic [7:0] pin;
        logic [7:0] ref_lvl;
        logic [7:0] pend;
        logic [7:0] hold;
        logic [7:0] rdata;
        gpmlc_pins_t pins;
        gpmlc_modem_t m_first;
        gpmlc_modem_t m_second;
        logic rts_n;
        logic irq;
        logic soft_rst;
    } gpmlc_top_st_t;

    localparam gpmlc_top_st_t ST_RST = '{
        ctrl: PC_RST, extra_line_features_control: EF_RST, pin: STATE_RST, ref_lvl: STATE_RST,
        pins: '{out: '0, oe_n: '1}, m_first: MODEM_IDLE,
        m_second: MODEM_IDLE, rts_n: 1'b1, default: '0};

    function automatic gpmlc_modem_t modem_of(input logic [3:0] nib);
        gpmlc_modem_t m;
        m.ring_indicate_n = nib[MP_RING];
        m.carrier_detect_n = nib[MP_CD];
        m.set_ready_n = nib[MP_DSR];
        return m;
    endfunction

    logic [1:0] rst_sync_q;
    logic rst_n;
    gpmlc_top_st_t q, d;
    logic lo, hi, latch, auto_dir, inv, st_rd;
    logic [7:0] en, evt, sel, view;

    ////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////
    // register, pin and direction logic
    assign lo = q.ctrl[PC_LO_MODEM];
    assign hi = q.ctrl[PC_HI_MODEM];
    assign latch = q.ctrl[PC_LATCH];
    assign auto_dir = q.extra_line_features_control[EF_RS485_AUTO];
    assign inv = q.extra_line_features_control[EF_RS485_INV];
    assign st_rd = reg_req.rd && (reg_req.addr == OFS_PIN_STATE);
    assign en = pin_interrupt_enable & ~gpio_dir & ~{{4{hi}}, {4{lo}}}; // RQ13
    assign evt = en & (q.pin ^ q.ref_lvl); // RQ14
    assign sel = q.pend & {8{latch}};
    assign view = (sel & q.hold) | (~sel & q.pin); // RQ5

    always_comb begin
        d = q;
        d.soft_rst = 1'b0;
        d.pin = gpio_in;
        if (latch) begin
            d.pend = q.pend | evt; // RQ5
            d.hold = (q.pend & q.hold) | (~q.pend & q.pin);
        end else begin
            d.pend = evt; // RQ4
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_PIN_CTRL: d.rdata = q.ctrl;
                OFS_EXTRA: d.rdata = q.extra_line_features_control;
                OFS_PIN_STATE: d.rdata = view;
                default: d.rdata = '0;
            endcase
        end
        if (st_rd) begin
            d.ref_lvl = q.pin; // RQ14
            d.pend = '0;
        end
        if (reg_req.wr && reg_req.addr == OFS_PIN_CTRL) begin
            d.ctrl = reg_req.wdata & PC_WMASK;
        end
        if (reg_req.wr && reg_req.addr == OFS_EXTRA) begin
            d.extra_line_features_control = reg_req.wdata & EF_WMASK;
        end
        // low nibble: gpio or second channel modem
        if (lo) begin // RQ2
            d.pins.oe_n[3:0] = MODEM_OE_N;
            d.pins.out[3:0] = {2'h0, terminal_ready_second_n, 1'b0};
            d.m_second = modem_of(gpio_in[3:0]);
        end else begin
            d.pins.oe_n[3:0] = ~gpio_dir[3:0];
            d.pins.out[3:0] = gpio_out_val[3:0];
            d.m_second = MODEM_IDLE;
        end
        // high nibble: gpio or first channel modem
        if (hi) begin // RQ3
            d.pins.oe_n[7:4] = MODEM_OE_N;
            d.pins.out[7:4] = {2'h0, terminal_ready_first_n, 1'b0};
            d.m_first = modem_of(gpio_in[7:4]);
        end else begin
            d.pins.oe_n[7:4] = ~gpio_dir[7:4];
            d.pins.out[7:4] = gpio_out_val[7:4];
            d.m_first = MODEM_IDLE;
        end
        // transmitter owns rts only in auto mode
        if (auto_dir) begin // RQ8 RQ11
            d.rts_n = uart_txing ? inv : ~inv; // RQ9 RQ10
        end else begin
            d.rts_n = rts_req_n; // RQ11
        end
        // soft reset: one cycle pulse in the same cycle fields go back to default, pin and ref_lvl load gpio_in
        if (q.ctrl[PC_SWRST]) begin // RQ12
            d = ST_RST; // RQ1
            d.soft_rst = 1'b1;
            d.pin = gpio_in;
            d.ref_lvl = gpio_in;
        end
        d.irq = |d.pend;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rsp.rdata = q.rdata;
    assign gpio_pins = q.pins;
    assign modem_first = q.m_first;
    assign modem_second = q.m_second;
    assign rts_n = q.rts_n;
    assign extra_ctrl = q.extra_line_features_control;
    assign soft_rst = q.soft_rst;
    assign pin_irq = q.irq;

    gpmlc_ir_enc u_ir (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clr(q.soft_rst),
        .tick16(tick16),
        .bit_start(tx_bit_start),
        .txd(txd),
        .mode(q.extra_line_features_control[EF_IR_MODE]),
        .ir_tx(ir_tx)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_swrst_clear;
        reg_req.wr && reg_req.addr == OFS_PIN_CTRL
            && reg_req.wdata[PC_SWRST] && !q.ctrl[PC_SWRST]
            |=> q.ctrl[PC_SWRST] ##1 (!q.ctrl[PC_SWRST] && soft_rst);
    endproperty
    a_swrst_clear: assert property (p_swrst_clear) else $error("soft reset bit stuck"); // RQ1

    property p_swrst_effect;
        q.ctrl[PC_SWRST] |=> q.extra_line_features_control == EF_RST && q.pend == '0
            && q.ctrl == PC_RST;
    endproperty
    a_swrst_effect: assert property (p_swrst_effect) else $error("soft reset missed state"); // RQ12

    property p_lo_modem;
        lo && !q.ctrl[PC_SWRST] |=> gpio_pins.oe_n[3:0] == MODEM_OE_N
            && gpio_pins.out[MP_DTR] == $past(terminal_ready_second_n);
    endproperty
    a_lo_modem: assert property (p_lo_modem) else $error("low nibble not modem"); // RQ2

    property p_hi_gpio;
        !hi && !q.ctrl[PC_SWRST]
            |=> gpio_pins.out[7:4] == $past(gpio_out_val[7:4])
            && modem_first == MODEM_IDLE;
    endproperty
    a_hi_gpio: assert property (p_hi_gpio) else $error("high nibble not gpio"); // RQ3

    property p_no_latch;
        !latch && q.pin == q.ref_lvl && !q.ctrl[PC_SWRST] |=> !pin_irq;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("reverted input kept flag"); // RQ4

    property p_latch_hold;
        latch && pin_irq && !st_rd && !q.ctrl[PC_SWRST]
            && !(reg_req.wr && reg_req.addr == OFS_PIN_CTRL)
            |=> pin_irq [*1] ##0 (q.hold & $past(q.pend))
            == ($past(q.hold) & $past(q.pend));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag lost"); // RQ5

    property p_rts_auto;
        auto_dir && !q.ctrl[PC_SWRST] |=> rts_n == ($past(uart_txing)
            ? $past(inv) : !$past(inv));
    endproperty
    a_rts_auto: assert property (p_rts_auto) else $error("rts polarity wrong"); // RQ9

    property p_rts_inv_tx;
        auto_dir && inv && uart_txing && !q.ctrl[PC_SWRST] |=> rts_n;
    endproperty
    a_rts_inv_tx: assert property (p_rts_inv_tx) else $error("inverted rts low in tx"); // RQ10

    property p_rts_manual;
        !auto_dir && !q.ctrl[PC_SWRST] |=> rts_n == $past(rts_req_n);
    endproperty
    a_rts_manual: assert property (p_rts_manual) else $error("rts not manual"); // RQ8

    property p_rts_owner;
        auto_dir && !q.ctrl[PC_SWRST] ##1 $changed(rts_req_n)
            && !q.ctrl[PC_SWRST] && $stable(uart_txing) && $stable(q.extra_line_features_control)
            |=> $stable(rts_n);
    endproperty
    a_rts_owner: assert property (p_rts_owner) else $error("rts follows manual"); // RQ11

    property p_modem_mask;
        lo || hi |=> (q.pend & ~$past(q.pend)
            & $past({{4{hi}}, {4{lo}}})) == 8'h00;
    endproperty
    a_modem_mask: assert property (p_modem_mask) else $error("modem pin flagged"); // RQ13

    property p_irq_set;
        |evt && !st_rd && !q.ctrl[PC_SWRST] |=> pin_irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("change not flagged"); // RQ14

    property p_irq_clear;
        st_rd && !latch && !q.ctrl[PC_SWRST] |=> !pin_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("read left flag"); // RQ14

    c_swrst: cover property (q.ctrl[PC_SWRST] ##1 soft_rst);
    c_latched: cover property (latch && pin_irq && q.pin == q.ref_lvl);
    c_rts_tx: cover property (auto_dir && uart_txing ##1 rts_n == inv);
    c_modem: cover property (lo && hi ##1 gpio_pins.oe_n == {2{MODEM_OE_N}});
endmodule
`default_nettype wire

// [common/gpmlc_pkg.sv]
// constants and carriers for the pin function and line feature control
// assumes one 125 MHz core clock and a decoded register port upstream
`default_nettype none
package gpmlc_pkg;
    // register offsets on the 4-bit register port
    localparam logic [3:0] OFS_PIN_STATE = 4'hB;
    localparam logic [3:0] OFS_PIN_CTRL = 4'hE;
    localparam logic [3:0] OFS_EXTRA = 4'hF;
    // pin_function_and_reset_control fields
    localparam int PC_SWRST = 3;
    localparam int PC_LO_MODEM = 2;
    localparam int PC_HI_MODEM = 1;
    localparam int PC_LATCH = 0;
    localparam logic [7:0] PC_WMASK = 8'h0F;
    localparam logic [7:0] PC_RST = 8'h00;
    // extra_line_features_control fields
    localparam int EF_IR_MODE = 7;
    localparam int EF_RS485_INV = 5;
    localparam int EF_RS485_AUTO = 4;
    localparam logic [7:0] EF_WMASK = 8'hB7;
    localparam logic [7:0] EF_RST = 8'h00;
    // pin state view after reset
    localparam logic [7:0] STATE_RST = 8'hFF;
    // modem signal position inside a nibble
    localparam int MP_RING = 3;
    localparam int MP_CD = 2;
    localparam int MP_DTR = 1;
    localparam int MP_DSR = 0;
    localparam logic [3:0] MODEM_OE_N = 4'hD;
    // infrared pulse widths in 16x ticks
    localparam logic [3:0] IR_W_STD = 4'h3;
    localparam logic [3:0] IR_W_FAST = 4'h4;
    localparam logic [3:0] IR_CNT_MAX = 4'hF;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } gpmlc_reg_req_t;

    typedef struct packed {
        logic [7:0] rdata;
    } gpmlc_reg_rsp_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } gpmlc_pins_t;

    typedef struct packed {
        logic ring_indicate_n;
        logic carrier_detect_n;
        logic set_ready_n;
    } gpmlc_modem_t;

    localparam gpmlc_modem_t MODEM_IDLE = 3'h7;
endpackage
`default_nettype wire

// [hdl/gpmlc_ir_enc.sv]
// infrared pulse shaper for one transmitted bit
// assumes a 16x bit-rate tick enable and a bit start pulse from the uart
`default_nettype none
`timescale 1ns/1ns
module gpmlc_ir_enc (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic tick16,
    input wire logic bit_start,
    input wire logic txd,
    input wire logic mode,
    output logic ir_tx
);
    import gpmlc_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic out;
        logic [3:0] tks;
    } gpmlc_ir_st_t;

    gpmlc_ir_st_t q, d;
    logic [3:0] width;

    assign width = mode ? IR_W_FAST : IR_W_STD;
    assign ir_tx = q.out;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        if (clr) begin
            d = '0;
        end else if (bit_start) begin
            d.cnt = '0;
            d.out = ~txd;
            d.tks = '0;
        end else if (tick16) begin
            if (q.cnt != IR_CNT_MAX) begin
                d.cnt = q.cnt + 4'h1;
            end
            // pulse only for a zero bit, 3 or 4 of 16 ticks
            if (d.cnt >= width) begin // RQ6 RQ7
                d.out = 1'b0;
            end
            if (q.out) begin
                d.tks = q.tks + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_ir_std;
        $fell(q.out) && !$past(clr) && !$past(bit_start) && !mode
            && $stable(mode) |-> q.tks == IR_W_STD;
    endproperty
    a_ir_std: assert property (p_ir_std) else $error("ir pulse not 3/16"); // RQ6

    property p_ir_fast;
        $fell(q.out) && !$past(clr) && !$past(bit_start) && mode
            && $stable(mode) |-> q.tks == IR_W_FAST;
    endproperty
    a_ir_fast: assert property (p_ir_fast) else $error("ir pulse not 1/4"); // RQ7

    property p_ir_cov;
        bit_start && !txd && !clr ##1 q.out [*2];
    endproperty
    c_ir_cov: cover property (p_ir_cov);
endmodule
`default_nettype wire

// [dv/gpmlc_host_model.sv]
// host side of the register port: one write or read cycle at a time
// assumes the bench calls wr and rd from a single process
`timescale 1ns/1ns
`default_nettype none
module gpmlc_host_model (
    input wire logic core_clk,
    output var gpmlc_pkg::gpmlc_reg_req_t reg_req,
    input wire gpmlc_pkg::gpmlc_reg_rsp_t reg_rsp
);
    import gpmlc_pkg::*;
    ////////////////////////////////////////
    // idle lines show the inverse of the last value, never a stale copy
    initial reg_req = '0;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_req = '{1'b1, 1'b0, a, d};
        @(posedge core_clk);
        #1 reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_req = '{1'b0, 1'b1, a, ~reg_req.wdata};
        @(posedge core_clk);
        #1 reg_req = '{1'b0, 1'b0, ~a, ~reg_req.wdata};
        @(posedge core_clk);
        #1 d = reg_rsp.rdata;
    endtask
endmodule
`default_nettype wire

// [dv/gpmlc_tb_top.sv]
// self-checking bench for pin function and line feature control
// assumes the host model drives the register port, 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module gpmlc_tb_top;
    import gpmlc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    gpmlc_reg_req_t reg_req;
    gpmlc_reg_rsp_t reg_rsp;
    gpmlc_pins_t gpio_pins;
    gpmlc_modem_t modem_first, modem_second;
    logic [7:0] gpio_in = 8'hFF, gpio_dir = 8'h00, gpio_out_val = 8'h00;
    logic [7:0] pin_interrupt_enable = 8'h00, extra_ctrl;
    logic terminal_ready_first_n = 1'b1, terminal_ready_second_n = 1'b1;
    logic uart_txing = 1'b0, rts_req_n = 1'b1, tick16 = 1'b0, txd = 1'b1;
    logic tx_bit_start = 1'b0, rts_n, ir_tx, soft_rst, pin_irq;
    int miscompares = 0, n_checks = 0, cyc = 0, nsr = 0, ef_m = 0, pc_m = 0;
    ////////////////////////////////////////
    gpmlc_host_model host (.core_clk, .reg_req, .reg_rsp);
    gpmlc_top dut (.core_clk, .rstn, .reg_req, .reg_rsp, .gpio_in, .gpio_dir,
        .gpio_out_val, .pin_interrupt_enable, .gpio_pins,
        .terminal_ready_first_n, .terminal_ready_second_n, .modem_first,
        .modem_second, .uart_txing, .rts_req_n, .rts_n, .tick16, .tx_bit_start,
        .txd, .ir_tx, .extra_ctrl, .soft_rst, .pin_irq);
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (soft_rst === 1'b1) nsr++;
        if (cyc == 5000) begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////////////
    task automatic summarize();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cy(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // write through the host and keep the register model in step
    task automatic mw(input logic [3:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a == OFS_EXTRA) ef_m = int'(d & EF_WMASK);
        if (a == OFS_PIN_CTRL) pc_m = d[PC_SWRST] ? 0 : int'(d & 8'h07);
        if (a == OFS_PIN_CTRL && d[PC_SWRST]) ef_m = 0;
    endtask
    task automatic mr(input logic [3:0] a);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, 8'((a == OFS_EXTRA) ? ef_m : (a == OFS_PIN_CTRL) ? pc_m : 0))
    endtask
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic e;
        int n, p, w;
        void'($urandom(32'hC454));
        repeat (2) @(posedge core_clk);
        #1 rstn = 1'b1;
        cy(3);
        `CHK(rts_n, 1'b1)
        mr(OFS_PIN_CTRL);
        mr(OFS_EXTRA);
        mr(4'h3);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            mw(OFS_EXTRA, d);
            mr(OFS_EXTRA);
            mw(OFS_PIN_CTRL, d & 8'hF7);
            mr(OFS_PIN_CTRL);
            mw(4'h3, d);
        end
        for (int k = 0; k < 16; k++) begin
            d = {2'b00, k[1], k[0], 4'h0};
            mw(OFS_EXTRA, d);
            uart_txing = k[2];
            rts_req_n = k[3];
            cy(3);
            e = k[0] ? (k[2] ? k[1] : !k[1]) : k[3];
            `CHK(rts_n, e)
            `CHK(extra_ctrl, d)
            rts_req_n = !k[3];
            cy(2);
            `CHK(rts_n, (k[0] ? e : !k[3]))
        end
        for (int s = 0; s < 4; s++) begin
            mw(OFS_PIN_CTRL, {5'h00, s[0], s[1], 1'b0});
            {gpio_in, gpio_dir, gpio_out_val} = 24'($urandom);
            {terminal_ready_first_n, terminal_ready_second_n} = 2'($urandom);
            cy(3);
            d = gpio_in;
            `CHK(modem_second, (s[0] ? {d[3:2], d[0]} : 3'h7))
            `CHK(modem_first, (s[1] ? {d[7:6], d[4]} : 3'h7))
            d = ~gpio_dir;
            `CHK(gpio_pins.oe_n[3:0], (s[0] ? MODEM_OE_N : d[3:0]))
            `CHK(gpio_pins.oe_n[7:4], (s[1] ? MODEM_OE_N : d[7:4]))
            e = s[0] ? terminal_ready_second_n : gpio_out_val[1];
            `CHK(gpio_pins.out[1], e)
            e = s[1] ? terminal_ready_first_n : gpio_out_val[5];
            `CHK(gpio_pins.out[5], e)
        end
        gpio_in = 8'hFF;
        gpio_dir = 8'h00;
        for (int c = 0; c < 4; c++) begin
            p = int'($urandom % 8);
            pin_interrupt_enable = (c == 3) ? ~(8'h01 << p) : 8'hFF;
            mw(OFS_PIN_CTRL, {5'h00, c == 2, c == 2, c == 1});
            host.rd(OFS_PIN_STATE, d);
            gpio_in[p] = 1'b0;
            cy(3);
            `CHK(pin_irq, c < 2)
            gpio_in[p] = 1'b1;
            cy(3);
            `CHK(pin_irq, c == 1)
            host.rd(OFS_PIN_STATE, d);
            if (c < 2) `CHK(d, ((c == 1) ? ~(8'h01 << p) : 8'hFF))
            cy(1);
            `CHK(pin_irq, 1'b0)
        end
        for (int m = 0; m < 3; m++) begin
            mw(OFS_EXTRA, {m[0], 7'h00});
            w = (m == 1) ? int'(IR_W_FAST) : int'(IR_W_STD);
            n = 0;
            for (int i = 0; i < 80; i++) begin
                tick16 = (i % 8 == 7);
                tx_bit_start = (i == 1);
                txd = (m == 2);
                cy(1);
                n += int'(ir_tx);
            end
            tick16 = 1'b0;
            `CHK(ir_tx, 1'b0)
            e = (m == 2) ? (n == 0) : (n >= 8 * w - 3 && n <= 8 * w + 1);
            `CHK(e, 1'b1)
        end
        mw(OFS_EXTRA, 8'hFF);
        nsr = 0;
        mw(OFS_PIN_CTRL, 8'h0F);
        cy(4);
        `CHK(nsr, 1)
        mr(OFS_PIN_CTRL);
        mr(OFS_EXTRA);
        `CHK(extra_ctrl, 8'h00)
        summarize();
    end
endmodule
`default_nettype wire
